// ==== rtl/adc_sweep_sequencer.sv ====
// Sweep sequencer with APB register file for a multi-channel delta-sigma converter
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adc_sweep_map.svh"
module adc_sweep_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire adc_sweep_pkg::word_t pwdata,
   output adc_sweep_pkg::word_t prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] sample_in,
   input wire logic overload_in,
   input wire logic sinc_range_in,
   input wire logic cascade_range_in,
   output logic combined_irq,
   output logic [7:0] power_enables,
   output logic converter_clk_en,
   output logic analog_reset,
   output logic converting,
   output logic [4:0] active_channel
);
   import adc_sweep_pkg::*;

   // ***************************************************************
   // Storage
   // ***************************************************************
   word_t power_cfg;
   word_t chan_cfg [0:24];
   word_t timing_cfg;
   word_t seq_cfg;
   word_t stab_cfg;
   word_t result [0:`CHAN_COUNT-1];
   logic [`CHAN_COUNT-1:0] chan_done;
   logic all_done;
   logic done_flag;
   logic midtrig_flag;
   logic stop_pending;
   seq_state_t state;
   logic [7:0] cycle_cnt;
   logic [4:0] chan;
   logic sync_first_ovl;
   logic sync_first_sinc;
   logic sync_first_casc;
   logic ovl_s;
   logic sinc_s;
   logic casc_s;

   // ***************************************************************
   // Decode
   // ***************************************************************
   logic wr_en;
   logic rd_en;
   logic trigger_wr;
   logic stop_wr;
   logic [`CHAN_COUNT-1:0] enables;
   logic adc_on;
   logic single_sweep;
   logic [4:0] highest;
   logic [4:0] next_chan;
   logic have_next;
   logic addr_mapped;
   logic [4:0] chan_index;
   logic [4:0] res_index;
   logic is_chan;
   logic is_result;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign trigger_wr = wr_en && paddr == `OFS_COMMAND_CONFIG && pwdata[`BIT_TRIGGER];
   assign stop_wr = wr_en && paddr == `OFS_COMMAND_CONFIG && pwdata[`BIT_STOP_CONT];
   assign enables = seq_cfg[`SEQ_ENABLES_HI:`SEQ_ENABLES_LO];
   assign adc_on = power_cfg[`BIT_ADC_ENABLE];
   assign single_sweep = power_cfg[`BIT_SINGLE_SWEEP];
   assign is_chan = paddr >= `OFS_SE_CHAN_FIRST && paddr <= `OFS_TEMPERATURE_CHANNEL_CONFIG;
   assign is_result = paddr >= `OFS_RESULT_FIRST && paddr <= `OFS_RESULT_LAST;
   assign chan_index = 5'(paddr[7:2] - 6'h04);
   assign res_index = 5'(paddr[7:2] - 6'h24);
   assign addr_mapped = paddr[1:0] == 2'h0 && (is_chan || is_result
      || paddr == `OFS_POWER_ENABLE_CONFIG || paddr == `OFS_COMMAND_CONFIG
      || paddr == `OFS_TIMING_CONTROL || paddr == `OFS_SEQUENCE_CONTROL
      || paddr == `OFS_MODULATOR_STABILITY_CONTROL || paddr == `OFS_INTERRUPT_FLAGS);

   // Highest enabled channel and next enabled channel above the current one
   always_comb begin
      highest = 5'h00;
      next_chan = 5'h00;
      have_next = 1'b0;
      for (int i = 0; i < `CHAN_COUNT; i++) begin
         if (enables[i]) begin
            highest = 5'(i);
         end
      end
      for (int i = `CHAN_COUNT - 1; i >= 0; i--) begin
         if (enables[i] && 5'(i) > chan) begin
            next_chan = 5'(i);
            have_next = 1'b1;
         end
      end
   end

   // ***************************************************************
   // Input synchronisers (overload and range flags arrive from analog)
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_first_ovl <= 1'b0;
         sync_first_sinc <= 1'b0;
         sync_first_casc <= 1'b0;
         ovl_s <= 1'b0;
         sinc_s <= 1'b0;
         casc_s <= 1'b0;
      end else begin
         sync_first_ovl <= overload_in;
         sync_first_sinc <= sinc_range_in;
         sync_first_casc <= cascade_range_in;
         ovl_s <= sync_first_ovl;
         sinc_s <= sync_first_sinc;
         casc_s <= sync_first_casc;
      end
   end
   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_cfg <= `POWER_RESET;
         timing_cfg <= 32'h0000_0000;
         seq_cfg <= 32'h0000_0000;
      end else if (wr_en) begin
         // Power config bits outside the write mask stay zero so a careless write cannot set them
         if (paddr == `OFS_POWER_ENABLE_CONFIG)
            power_cfg <= pwdata & `POWER_WRITE_MASK;
         if (paddr == `OFS_TIMING_CONTROL)
            timing_cfg <= pwdata;
         if (paddr == `OFS_SEQUENCE_CONTROL)
            seq_cfg <= pwdata;
      end
   end

   // Channel configuration words, one per channel slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 25; i++) begin
            chan_cfg[i] <= 32'h0000_0000;
         end
      end else if (wr_en && is_chan && paddr[1:0] == 2'h0) begin
         chan_cfg[chan_index] <= pwdata;
      end
   end

   // Stability control: overload flag set by hardware, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_cfg <= 32'h0000_0000;
      end else begin
         if (wr_en && paddr == `OFS_MODULATOR_STABILITY_CONTROL)
            stab_cfg <= pwdata;
         if (ovl_s && adc_on)
            stab_cfg[`STAB_BIT_OVERLOAD] <= 1'b1;
      end
   end

   // ***************************************************************
   // Sweep state machine
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
         cycle_cnt <= 8'h00;
         chan <= 5'h00;
         stop_pending <= 1'b0;
         midtrig_flag <= 1'b0;
      end else if (!adc_on) begin
         state <= st_idle;
         stop_pending <= 1'b0;
      end else begin
         if (stop_wr && !single_sweep)
            stop_pending <= 1'b1;
         case (state)
            st_idle: begin
               if (trigger_wr && enables != '0) begin
                  chan <= 5'h00;
                  state <= st_delay;
                  // Zero-based count: field 00 waits one modulator clock
                  cycle_cnt <= {6'h00, power_cfg[`BIT_START_DELAY_HI:`BIT_START_DELAY_LO]};
                  midtrig_flag <= 1'b0;
                  stop_pending <= 1'b0;
               end
            end
            st_delay: begin
               if (cycle_cnt == 8'h00) begin
                  state <= st_convert;
                  cycle_cnt <= `CONV_CYCLES;
                  if (!enables[chan])
                     state <= st_next;
               end else begin
                  cycle_cnt <= cycle_cnt - 8'h01;
               end
            end
            st_convert: begin
               if (trigger_wr) begin
                  midtrig_flag <= 1'b1;
                  state <= st_delay;
                  cycle_cnt <= {6'h00, power_cfg[`BIT_START_DELAY_HI:`BIT_START_DELAY_LO]};
               end else if (cycle_cnt == 8'h00) begin
                  state <= st_next;
               end else begin
                  cycle_cnt <= cycle_cnt - 8'h01;
               end
            end
            default: begin
               if (have_next) begin
                  chan <= next_chan;
                  state <= st_delay;
                  cycle_cnt <= {6'h00, power_cfg[`BIT_START_DELAY_HI:`BIT_START_DELAY_LO]};
               end else if (single_sweep || stop_pending || stop_wr) begin
                  state <= st_idle;
                  stop_pending <= 1'b0;
               end else begin
                  chan <= 5'h00;
                  state <= st_delay;
                  cycle_cnt <= {6'h00, power_cfg[`BIT_START_DELAY_HI:`BIT_START_DELAY_LO]};
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // Results and completion flags
   // ***************************************************************
   logic store;
   assign store = state == st_convert && cycle_cnt == 8'h00 && !trigger_wr && adc_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `CHAN_COUNT; i++) begin
            result[i] <= 32'h0000_0000;
         end
      end else if (store) begin
         result[chan] <= {5'h00, midtrig_flag, stab_cfg[`STAB_BIT_OVERLOAD], sinc_s, casc_s,
            7'h00, 1'b0, midtrig_flag | stab_cfg[`STAB_BIT_OVERLOAD] | sinc_s | casc_s,
            sample_in[13:0]};
      end
   end

   // Channel flags: sweep start clears, conversion end sets (set wins)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_done <= '0;
         all_done <= 1'b0;
         done_flag <= 1'b0;
      end else begin
         if (state == st_idle && trigger_wr && adc_on && enables != '0) begin
            chan_done <= '0;
            all_done <= 1'b0;
            done_flag <= 1'b0;
         end else if (wr_en && paddr == `OFS_INTERRUPT_FLAGS) begin
            chan_done <= chan_done & ~pwdata[`CHAN_COUNT-1:0];
            all_done <= all_done & ~pwdata[`BIT_ALL_DONE];
         end
         if (store) begin
            chan_done[chan] <= 1'b1;
            if (chan == highest) begin
               all_done <= 1'b1;
               done_flag <= 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // Combined interrupt, gated per source then by master enable
   // ***************************************************************
   logic any_mid;
   logic any_sinc;
   logic any_casc;
   logic irq_next;
   always_comb begin
      any_mid = 1'b0;
      any_sinc = 1'b0;
      any_casc = 1'b0;
      for (int i = 0; i < `CHAN_COUNT; i++) begin
         any_mid = any_mid | result[i][`BIT_RES_MIDTRIG];
         any_sinc = any_sinc | result[i][`BIT_RES_SINC];
         any_casc = any_casc | result[i][`BIT_RES_CASCADE];
      end
      irq_next = power_cfg[`BIT_MASTER_IRQ_EN] & (
         (power_cfg[`BIT_DONE_IRQ_EN] & done_flag)
         | (power_cfg[`BIT_MIDTRIG_IRQ_EN] & any_mid)
         | (power_cfg[`BIT_OVERLOAD_IRQ_EN] & stab_cfg[`STAB_BIT_OVERLOAD])
         | (power_cfg[`BIT_SINC_IRQ_EN] & any_sinc)
         | (power_cfg[`BIT_CASCADE_IRQ_EN] & any_casc));
   end

   // ***************************************************************
   // Outputs and APB read path (one wait-free access phase)
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         combined_irq <= 1'b0;
         power_enables <= 8'h00;
         converter_clk_en <= 1'b0;
         analog_reset <= 1'b1;
         converting <= 1'b0;
         active_channel <= 5'h00;
      end else begin
         combined_irq <= irq_next;
         // Master enable off forces every block down, whatever its own bit
         power_enables <= adc_on ? power_cfg[10:3] : 8'h00;
         converter_clk_en <= adc_on;
         analog_reset <= ~adc_on;
         converting <= adc_on && state != st_idle;
         active_channel <= chan;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_mapped;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite && addr_mapped) begin
            if (is_chan)
               prdata <= chan_cfg[chan_index];
            else if (is_result)
               prdata <= res_index < 5'(`CHAN_COUNT) ? result[res_index] : 32'h0000_0000;
            else
               case (paddr)
                  `OFS_POWER_ENABLE_CONFIG: prdata <= power_cfg;
                  `OFS_COMMAND_CONFIG: prdata <= {29'h0, done_flag, 2'h0};
                  `OFS_TIMING_CONTROL: prdata <= timing_cfg;
                  `OFS_SEQUENCE_CONTROL: prdata <= seq_cfg;
                  `OFS_MODULATOR_STABILITY_CONTROL: prdata <= stab_cfg;
                  `OFS_INTERRUPT_FLAGS: prdata <= {all_done, 13'h0, chan_done};
                  default: prdata <= 32'h0000_0000;
               endcase
         end
      end
   end
endmodule // adc_sweep_sequencer

// ==== rtl/adc_sweep_map.svh ====
// Register offsets, field positions, reset values and timing counts of the sweep sequencer
// Function
// - Writing the trigger command bit starts converting the enabled channels, either mode.
// - Single-sweep select at 1: one pass over enabled channels, then wait for trigger.
// - Single-sweep select at 0: sweeps restart automatically after each one finishes.
// - Sweep done when highest enabled channel flag and combined done bit both read 1.
// - Writing 1 to stop-continuous halts conversion once the current sweep ends.
// - Bit 31 lets conversion completion raise the interrupt; 0 blocks it.
// - Bit 30 lets the mid-conversion trigger flag raise the interrupt; 0 blocks it.
// - Bit 29 lets the modulator overload flag raise the interrupt; 0 blocks it.
// - Bit 28 lets the sinc filter range flag raise the interrupt; 0 blocks it.
// - Bit 27 lets the cascade filter range flag raise the interrupt; 0 blocks it.
// - Master enable bit 24 gates the combined interrupt; 0 overrides bits 31:27.
// - Bits 15-14 set modulator clocks of start delay after reset; 00 means one.
// - A power enable bit at 0 forces its circuit into power-down.
// - Power config at 0x00, command 0x04, timing 0x74, sequence 0x78, stability 0x84, status 0x8c.
// - Defined fields of every register are readable and writable unless stated otherwise; power enable bits 6 and 8 of power config are masked and always read 0.
// - Master converter enable at 0 gates filter and converter clocks, holds analog reset.
// - Trigger during conversion sets mid-conversion flag and restarts; normal start clears it.
// - Summary error bit 14 of each data word is the OR of its other error flags.
`ifndef ADC_SWEEP_MAP_SVH
`define ADC_SWEEP_MAP_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define OFS_POWER_ENABLE_CONFIG 8'h00
`define OFS_COMMAND_CONFIG 8'h04
`define OFS_SE_CHAN_FIRST 8'h10
`define OFS_SE_CHAN_LAST 8'h4c
`define OFS_DIFF_CHAN_FIRST 8'h50
`define OFS_DIFF_CHAN_LAST 8'h6c
`define OFS_TEMPERATURE_CHANNEL_CONFIG 8'h70
`define OFS_TIMING_CONTROL 8'h74
`define OFS_SEQUENCE_CONTROL 8'h78
`define OFS_MODULATOR_STABILITY_CONTROL 8'h84
`define OFS_INTERRUPT_FLAGS 8'h8c
`define OFS_RESULT_FIRST 8'h90
`define OFS_RESULT_LAST 8'hd4

// ***************************************************************
// Power enable config fields
// ***************************************************************
`define BIT_DONE_IRQ_EN 31
`define BIT_MIDTRIG_IRQ_EN 30
`define BIT_OVERLOAD_IRQ_EN 29
`define BIT_SINC_IRQ_EN 28
`define BIT_CASCADE_IRQ_EN 27
`define BIT_MASTER_IRQ_EN 24
`define BIT_START_DELAY_HI 15
`define BIT_START_DELAY_LO 14
`define BIT_SINGLE_SWEEP 13
`define BIT_ADC_ENABLE 0
`define POWER_WRITE_MASK 32'hf900_e6bf
`define POWER_RESET 32'h0000_0000

// ***************************************************************
// Command config fields (write bits are momentary)
// ***************************************************************
`define BIT_TRIGGER 0
`define BIT_STOP_CONT 1
`define BIT_DONE_FLAG 2

// ***************************************************************
// Sequence control, interrupt flags, result word and stability control fields
// ***************************************************************
`define SEQ_ENABLES_HI 17
`define SEQ_ENABLES_LO 0
`define BIT_ALL_DONE 31
`define BIT_RES_CASCADE 23
`define BIT_RES_SINC 24
`define BIT_RES_OVERLOAD 25
`define BIT_RES_MIDTRIG 26
`define BIT_RES_ERROR 14
`define BIT_RES_RESERVED_ERR 15
`define STAB_BIT_OVERLOAD 31

// ***************************************************************
// Conversion timing count and channel count
// ***************************************************************
`define CONV_CYCLES 8'd32
`define CHAN_COUNT 18

`endif

// ==== rtl/adc_sweep_pkg.sv ====
// Types shared by the sweep sequencer
package adc_sweep_pkg;
   typedef enum logic [1:0] {st_idle, st_delay, st_convert, st_next} seq_state_t;
   typedef logic [31:0] word_t;
endpackage

// ==== verif/adc_sweep_sequencer_monitor.sv ====
// Checker of the sweep sequencer port behaviour, bound to the design top
`timescale 1ns/1ps
`include "adc_sweep_map.svh"
module adc_sweep_sequencer_monitor import adc_sweep_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire adc_sweep_pkg::word_t pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic combined_irq,
   input wire logic [7:0] power_enables,
   input wire logic converter_clk_en,
   input wire logic analog_reset,
   input wire logic converting,
   input wire logic [4:0] active_channel
);
   // ************
   // Shadow copies of written registers
   // ************
   logic wr_ok;
   logic unmapped;
   logic master;
   logic srcs;
   word_t power_q;
   logic [17:0] chans_q;
   assign wr_ok = psel && penable && pready && pwrite;
   assign master = power_q[`BIT_MASTER_IRQ_EN];
   assign srcs = |power_q[31:27];
   // Holes in the map; decoded here, not copied from the design
   assign unmapped = paddr[1:0] != 2'b00 || paddr == 8'h08 || paddr == 8'h0c ||
      paddr == 8'h7c || paddr == 8'h80 || paddr == 8'h88 || paddr > `OFS_RESULT_LAST;
   // Power config shadow, written only on a completed access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) power_q <= '0;
      else if (wr_ok && paddr == `OFS_POWER_ENABLE_CONFIG) power_q <= pwdata & `POWER_WRITE_MASK;
   end
   // Channel enable shadow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) chans_q <= '0;
      else if (wr_ok && paddr == `OFS_SEQUENCE_CONTROL) chans_q <= pwdata[17:0];
   end
   // ************
   // Assertions
   // ************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   setup_gets_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_needs_setup_a: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   slverr_decode_a: assert property (pready |-> pslverr == unmapped)
      else $error("error response does not match address");
   clock_gate_pair_a: assert property (converter_clk_en != analog_reset)
      else $error("clock enable and analog reset disagree");
   power_down_a: assert property (!converter_clk_en |-> power_enables == 8'h00)
      else $error("block enabled while converter off");
   enable_follow_a: assert property (wr_ok && paddr == `OFS_POWER_ENABLE_CONFIG |->
      ##2 power_enables == (power_q[0] ? power_q[10:3] : 8'h00))
      else $error("power enables do not follow register");
   irq_master_gate_a: assert property (combined_irq |->
      master || $past(master) || $past(master, 2))
      else $error("interrupt with master enable off");
   irq_source_a: assert property (combined_irq |-> srcs || $past(srcs) || $past(srcs, 2))
      else $error("interrupt with no source enabled");
   trigger_start_a: assert property (wr_ok && paddr == `OFS_COMMAND_CONFIG && pwdata[0] &&
      converter_clk_en && chans_q != 0 && !converting |-> ##[1:8] converting)
      else $error("trigger did not start a sweep");
   channel_range_a: assert property (converting |-> active_channel < 5'd18)
      else $error("active channel out of range");
   // Main scenarios reached
   cover property (wr_ok && paddr == `OFS_COMMAND_CONFIG && pwdata[0]);
   cover property ($fell(converting));
   cover property ($rose(combined_irq));
endmodule // adc_sweep_sequencer_monitor

bind adc_sweep_sequencer adc_sweep_sequencer_monitor u_monitor (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .combined_irq(combined_irq),
   .power_enables(power_enables), .converter_clk_en(converter_clk_en),
   .analog_reset(analog_reset), .converting(converting), .active_channel(active_channel));

// ==== verif/adc_sweep_sequencer_bench.sv ====
// Self-checking bench of the sweep sequencer over APB
`timescale 1ns/1ps
`include "adc_sweep_map.svh"
module adc_sweep_sequencer_bench;
   import adc_sweep_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic pready, pslverr, combined_irq, converter_clk_en, analog_reset, converting;
   logic overload_in = 0, sinc_range_in = 0, cascade_range_in = 0;
   logic [7:0] paddr = 8'h00;
   logic [7:0] power_enables;
   logic [4:0] active_channel;
   logic [15:0] sample_in = 16'h0000;
   word_t pwdata = 32'h0, prdata, rd, d, m;
   int errors = 0, comparisons = 0, cycles = 0, seed = 21, k, e, lat[2];
   logic [7:0] rw_addr[6] = '{8'h10, 8'h4c, 8'h50, 8'h6c, 8'h70, 8'h74};
   logic [7:0] bad_addr[4] = '{8'h08, 8'h80, 8'h88, 8'h02};
   word_t irq_pw[8] = '{32'h8000_0001, 32'h8100_0001, 32'h0100_0001, 32'h2100_0001,
      32'h2000_0001, 32'h1100_0001, 32'h0900_0001, 32'h4100_0001};
   logic irq_ex[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

   adc_sweep_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_in(sample_in), .overload_in(overload_in),
      .sinc_range_in(sinc_range_in), .cascade_range_in(cascade_range_in),
      .combined_irq(combined_irq), .power_enables(power_enables),
      .converter_clk_en(converter_clk_en), .analog_reset(analog_reset),
      .converting(converting), .active_channel(active_channel));

   // ************
   // Clock, hang guard and shared tasks
   // ************
   always #50 pclk = ~pclk;
   // A stuck handshake must still end with a verdict
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test;
      end
   end
   task stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input word_t s, input word_t x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // One transfer; the request stands until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input word_t dw);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dw;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_lvl(input logic l);
      while (converting !== l) begin
         @(posedge pclk);
      end
   endtask
   task busy(input int n);
      k = 0;
      repeat (n) begin
         @(posedge pclk);
         if (converting === 1'b1) k++;
      end
   endtask
   // Single sweep with a chosen start delay, timed from the trigger
   task sweep(input logic [1:0] f, output int t);
      int t0;
      apb(1'b1, `OFS_POWER_ENABLE_CONFIG, {16'h0000, f, 14'h2001});
      sample_in <= 16'($random(seed));
      repeat (4) @(posedge pclk);
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h1);
      t0 = cycles;
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      t = cycles - t0;
   endtask

   // ************
   // Main sequence
   // ************
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_POWER_ENABLE_CONFIG, 32'h0);
      chk(rd, `POWER_RESET);
      chk(analog_reset, 1'b1);
      chk(power_enables, 8'h00);
      apb(1'b1, `OFS_SEQUENCE_CONTROL, 32'h5);
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h1);
      busy(50);
      chk(k, 0);
      $display("test reset and refused trigger done");
      repeat (8) begin
         d = $random(seed);
         apb(1'b1, `OFS_POWER_ENABLE_CONFIG, d);
         apb(1'b0, `OFS_POWER_ENABLE_CONFIG, 32'h0);
         m = d & `POWER_WRITE_MASK;
         chk(rd, m);
         chk(power_enables, m[0] ? m[10:3] : 8'h00);
         chk(analog_reset, !d[0]);
      end
      foreach (rw_addr[i]) begin
         d = $random(seed);
         apb(1'b1, rw_addr[i], d);
         apb(1'b0, rw_addr[i], 32'h0);
         chk(err, 1'b0);
         chk(rd, d);
      end
      foreach (bad_addr[i]) begin
         apb(1'b1, bad_addr[i], 32'hffff_ffff);
         chk(err, 1'b1);
         apb(1'b0, bad_addr[i], 32'h0);
         chk(err, 1'b1);
         chk(rd, 32'h0);
      end
      $display("test register access done");
      // Two channels of delay, conversion and step cycle, plus output lag
      e = 2 * (`CONV_CYCLES + 3) + 2;
      sweep(2'b00, lat[0]);
      sweep(2'b11, lat[1]);
      chk(lat[0] > e - 4 && lat[0] < e + 4, 1'b1);
      chk(lat[1] - lat[0], 6);
      apb(1'b0, `OFS_INTERRUPT_FLAGS, 32'h0);
      chk(rd & 32'h8000_0007, 32'h8000_0005);
      apb(1'b0, `OFS_COMMAND_CONFIG, 32'h0);
      chk(rd[`BIT_DONE_FLAG], 1'b1);
      apb(1'b0, `OFS_RESULT_FIRST + 8'h08, 32'h0);
      chk(rd[13:0], sample_in[13:0]);
      chk(rd[14], |{rd[26:23], rd[15]});
      busy(200);
      chk(k, 0);
      $display("test single sweep done");
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h1);
      repeat (10) @(posedge pclk);
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h1);
      wait_lvl(1'b0);
      apb(1'b0, `OFS_RESULT_FIRST, 32'h0);
      chk(rd[26], 1'b1);
      chk(rd[14], 1'b1);
      sweep(2'b00, lat[0]);
      apb(1'b0, `OFS_RESULT_FIRST, 32'h0);
      chk(rd[26], 1'b0);
      $display("test mid-conversion trigger done");
      sinc_range_in <= 1'b1;
      apb(1'b1, `OFS_POWER_ENABLE_CONFIG, 32'h1);
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h1);
      busy(400);
      chk(k > 390, 1'b1);
      apb(1'b1, `OFS_COMMAND_CONFIG, 32'h2);
      e = cycles;
      wait_lvl(1'b0);
      chk(cycles - e < 80, 1'b1);
      busy(200);
      chk(k, 0);
      $display("test continuous sweep done");
      // Done and sinc flags stay set; the overload source joins from entry three
      for (int i = 0; i < 8; i++) begin
         if (i == 3) overload_in <= 1'b1;
         apb(1'b1, `OFS_POWER_ENABLE_CONFIG, irq_pw[i]);
         repeat (5) @(posedge pclk);
         chk(combined_irq, irq_ex[i]);
      end
      $display("test interrupt gating done");
      stop_test;
   end
endmodule // adc_sweep_sequencer_bench
